// ### src/flash_dec_pkg.sv
// Constants and types shared by the flash instruction decoder
package flash_dec_pkg;
    // Low-order instruction addresses (only A11..A0 take part)
    localparam logic [11:0] CMD_ADDR_A   = 12'haaa;
    localparam logic [11:0] CMD_ADDR_B   = 12'h554;
    localparam logic [11:0] ID_ADDR      = 12'h002;
    localparam logic [11:0] PROT_ADDR    = 12'h004;
    // Instruction and confirmation bytes
    localparam logic [7:0]  UNLOCK1_DATA = 8'haa;
    localparam logic [7:0]  UNLOCK2_DATA = 8'h55;
    localparam logic [7:0]  AUTOSEL_CMD  = 8'h90;
    localparam logic [7:0]  PROGRAM_CMD  = 8'ha0;
    localparam logic [7:0]  ERASE_CMD    = 8'h80;
    localparam logic [7:0]  SECTOR_CMD   = 8'h30;
    localparam logic [7:0]  BULK_CMD     = 8'h10;
    localparam logic [7:0]  SUSPEND_CMD  = 8'hb0;
    localparam logic [7:0]  RESET_CMD    = 8'hf0;
    localparam logic [7:0]  BYPASS_CMD   = 8'h20;
    localparam logic [7:0]  BYP_EXIT_CMD = 8'h00;
    // Status word bit positions
    localparam int          POLL_BIT     = 7;
    localparam int          TOGGLE_BIT   = 6;
    localparam int          ERROR_BIT    = 5;
    localparam int          ERASE_TO_BIT = 3;
    // Reset values
    localparam logic [15:0] RDATA_RST    = 16'h0000;
    // Timing: longest times round down to whole cycles
    localparam int          CLK_PERIOD_NS = 25;
    localparam int          BYTE_TO_NS    = 100000;
    localparam int          ERASE_WIN_NS  = 80000;
    localparam int          BYTE_TO_CYC   = BYTE_TO_NS / CLK_PERIOD_NS;
    localparam int          ERASE_WIN_CYC = ERASE_WIN_NS / CLK_PERIOD_NS;
    // Decoder states, one-hot
    typedef enum logic [13:0] {
        ST_READ    = 14'h0001,
        ST_UNL1    = 14'h0002,
        ST_UNL2    = 14'h0004,
        ST_ID      = 14'h0008,
        ST_PROG    = 14'h0010,
        ST_ERA3    = 14'h0020,
        ST_ERA4    = 14'h0040,
        ST_ERA5    = 14'h0080,
        ST_WIN     = 14'h0100,
        ST_BYP     = 14'h0200,
        ST_BYP_PRG = 14'h0400,
        ST_BYP_RST = 14'h0800,
        ST_BUSY    = 14'h1000,
        ST_SUSP    = 14'h2000
    } dec_state_e;
endpackage : flash_dec_pkg

// ### src/flash_timer_if.sv
// Carrier between the decoder and its inter-byte timer
`timescale 1ns/1ps
`default_nettype none
interface flash_timer_if;
    logic restart;  // Pulse: a write byte was taken
    logic use_win;  // High: time the erase append window
    logic expired;  // Level: selected time has run out
    modport ctl (output restart, output use_win, input expired);
    modport tmr (input restart, input use_win, output expired);
endinterface : flash_timer_if
`default_nettype wire

// ### src/flash_byte_timer.sv
// Inter-byte time-out and erase append window counter
`timescale 1ns/1ps
`default_nettype none
module flash_byte_timer #(
    parameter int TO_CYC  = 4000,
    parameter int WIN_CYC = 3200,
    parameter int CW      = 12
) (
    // Clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rst_n,
    // Control from the decoder
    flash_timer_if.tmr tif
);
    // Saturating count would alias a limit at all-ones
    generate
        if (TO_CYC < 1 || WIN_CYC < 1 || TO_CYC >= 2**CW - 1 || WIN_CYC >= 2**CW - 1) begin : g_chk
            $error("flash_byte_timer: limits do not fit the counter");
        end
    endgenerate

    logic [CW-1:0] cnt;  // Cycles since the last byte
    wire  [CW-1:0] lim = tif.use_win ? CW'(WIN_CYC) : CW'(TO_CYC);

    // Restart on each byte, then count up and hold at the top
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt <= '0;
        end else if (tif.restart) begin
            cnt <= '0;
        end else if (cnt != '1) begin
            cnt <= cnt + 1'b1;
        end
    end

    assign tif.expired = (cnt >= lim);
endmodule : flash_byte_timer
`default_nettype wire

// ### src/flash_instruction_decoder.sv
// Flash instruction sequence decoder with status read path
`timescale 1ns/1ps
`default_nettype none
module flash_instruction_decoder
    import flash_dec_pkg::*;
#(
    parameter int          TO_CYC   = BYTE_TO_CYC,
    parameter int          WIN_CYC  = ERASE_WIN_CYC,
    parameter logic [7:0]  FLASH_ID = 8'h5a  // Arbitrary value
) (
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    // Host bus
    input  wire logic [15:0] i_addr,
    input  wire logic [15:0] i_data,
    input  wire logic        i_low_byte_write_strobe_n,
    input  wire logic        i_rd_n,
    input  wire logic [7:0]  i_primary_sector_selects,
    input  wire logic [3:0]  i_secondary_sector_selects,
    output logic      [15:0] o_rdata,
    // Array side
    input  wire logic [15:0] i_array_rdata,
    input  wire logic        i_sector_protected,
    input  wire logic        i_op_done,
    input  wire logic        i_op_error,
    output logic             o_prog_start,
    output logic      [15:0] o_program_location,
    output logic      [15:0] o_program_word,
    output logic             o_erase_start,
    output logic             o_erase_bulk,
    output logic      [11:0] o_erase_sectors,
    output logic             o_suspend,
    output logic             o_target_secondary,
    // Status
    output logic             o_busy_indicator_pin,
    output logic             o_read_mode
);
    dec_state_e state;       // Decoder state
    dec_state_e next_state;  // Following state
    logic       wr_q;        // Write strobe, last cycle
    logic       rd_q;        // Read strobe, last cycle
    logic [15:0] addr_l;     // Address caught at strobe fall
    logic [11:0] sel_l;      // Selects caught at strobe fall
    logic       byp;         // Bypass mode remembered over busy
    logic       er_sec;      // Running operation is a sector erase
    logic       err;         // Error flag, cleared by F0h
    logic       tog;         // Toggle status bit
    logic       poll;        // Data bit being programmed

    flash_timer_if tif ();

    flash_byte_timer #(
        .TO_CYC  (TO_CYC),
        .WIN_CYC (WIN_CYC),
        .CW      (12)
    ) u_timer (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .tif       (tif)
    );

    // Strobe edges; strobes are synchronous to the clock
    wire wr_fall = wr_q & ~i_low_byte_write_strobe_n;
    wire wr_rise = ~wr_q & i_low_byte_write_strobe_n;
    wire rd_fall = rd_q & ~i_rd_n;
    // A write counts only when a sector select was high
    wire wr_ok   = wr_rise & (|sel_l);
    // Live target for reads
    wire sel_p   = |i_primary_sector_selects;
    wire sel_s   = |i_secondary_sector_selects;

    // Command decode on the low twelve address bits
    wire [7:0] cmd = i_data[7:0];
    wire at_a  = (addr_l[11:0] == CMD_ADDR_A);
    wire at_b  = (addr_l[11:0] == CMD_ADDR_B);
    wire even  = ~addr_l[0];
    wire c_aa  = at_a && cmd == UNLOCK1_DATA;
    wire c_55  = at_b && cmd == UNLOCK2_DATA;
    wire c_90a = at_a && cmd == AUTOSEL_CMD;
    wire c_a0a = at_a && cmd == PROGRAM_CMD;
    wire c_80a = at_a && cmd == ERASE_CMD;
    wire c_20a = at_a && cmd == BYPASS_CMD;
    wire c_10a = at_a && cmd == BULK_CMD;
    wire c_30  = cmd == SECTOR_CMD;
    wire c_30e = even && cmd == SECTOR_CMD;
    wire c_b0e = even && cmd == SUSPEND_CMD;
    wire c_f0e = even && cmd == RESET_CMD;
    wire c_a0e = even && cmd == PROGRAM_CMD;
    wire c_90e = even && cmd == AUTOSEL_CMD;
    wire c_00e = even && cmd == BYP_EXIT_CMD;

    // States in which the inter-byte time-out applies
    wire in_seq = state inside {ST_UNL1, ST_UNL2, ST_PROG, ST_ERA3,
                                ST_ERA4, ST_ERA5, ST_BYP_PRG, ST_BYP_RST};
    wire tmo    = tif.expired;
    assign tif.restart = wr_ok;
    assign tif.use_win = (state == ST_WIN);

    // Starts of embedded operations
    wire start_prog = wr_ok && (state inside {ST_PROG, ST_BYP_PRG});
    wire start_bulk = wr_ok && state == ST_ERA5 && c_10a;
    wire start_sec  = !wr_ok && state == ST_WIN && tmo;
    wire add_sec    = wr_ok && c_30 && (state inside {ST_ERA5, ST_WIN});

    // Next-state decode of the instruction sequences
    always_comb begin
        next_state = state;
        unique case (state)
            ST_READ: begin
                if (wr_ok && c_aa) next_state = ST_UNL1;
            end
            ST_UNL1: begin
                if (wr_ok) next_state = c_55 ? ST_UNL2 : ST_READ;
            end
            ST_UNL2: begin
                if (wr_ok) begin
                    if (c_90a)      next_state = ST_ID;
                    else if (c_a0a) next_state = ST_PROG;
                    else if (c_80a) next_state = ST_ERA3;
                    else if (c_20a) next_state = ST_BYP;
                    else            next_state = ST_READ;
                end
            end
            // Any write leaves the ID view; F0h is the proper one
            ST_ID: begin
                if (wr_ok) next_state = ST_READ;
            end
            ST_PROG: begin
                if (wr_ok) next_state = ST_BUSY;
            end
            ST_ERA3: begin
                if (wr_ok) next_state = c_aa ? ST_ERA4 : ST_READ;
            end
            ST_ERA4: begin
                if (wr_ok) next_state = c_55 ? ST_ERA5 : ST_READ;
            end
            ST_ERA5: begin
                if (wr_ok) begin
                    if (c_10a)     next_state = ST_BUSY;
                    else if (c_30) next_state = ST_WIN;
                    else           next_state = ST_READ;
                end
            end
            // Append window: more 30h bytes extend the sector list
            ST_WIN: begin
                if (wr_ok)    next_state = c_30 ? ST_WIN : ST_READ;
                else if (tmo) next_state = ST_BUSY;
            end
            ST_BYP: begin
                if (wr_ok && c_a0e)      next_state = ST_BYP_PRG;
                else if (wr_ok && c_90e) next_state = ST_BYP_RST;
            end
            ST_BYP_PRG: begin
                if (wr_ok) next_state = ST_BUSY;
            end
            ST_BYP_RST: begin
                if (wr_ok) next_state = c_00e ? ST_READ : ST_BYP;
            end
            // Error holds here with the pin ready until F0h
            ST_BUSY: begin
                if (err) begin
                    if (wr_ok && c_f0e) next_state = ST_READ;
                end else if (i_op_error) begin
                    next_state = ST_BUSY;
                end else if (i_op_done) begin
                    next_state = byp ? ST_BYP : ST_READ;
                end else if (wr_ok && c_b0e && er_sec) begin
                    next_state = ST_SUSP;
                end
            end
            ST_SUSP: begin
                if (wr_ok && c_30e) next_state = ST_BUSY;
            end
            default: next_state = ST_READ;
        endcase
        // Stalled sequences fall back to plain reads
        if (in_seq && tmo && !wr_ok) next_state = ST_READ;
    end

    // State register; reset lands in read mode
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= ST_READ;
        end else begin
            state <= next_state;
        end
    end

    // Strobe history and address capture on the falling strobe
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_q   <= 1'b1;
            rd_q   <= 1'b1;
            addr_l <= '0;
            sel_l  <= '0;
        end else begin
            wr_q <= i_low_byte_write_strobe_n;
            rd_q <= i_rd_n;
            if (wr_fall) begin
                addr_l <= i_addr;
                sel_l  <= {i_secondary_sector_selects, i_primary_sector_selects};
            end
        end
    end

    // Mode flags kept across the busy phase
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            byp    <= 1'b0;
            er_sec <= 1'b0;
            err    <= 1'b0;
        end else begin
            if (next_state inside {ST_BYP, ST_BYP_PRG, ST_BYP_RST}) byp <= 1'b1;
            else if (next_state == ST_READ) byp <= 1'b0;
            if (start_sec) er_sec <= 1'b1;
            else if (start_prog || start_bulk || next_state == ST_READ) er_sec <= 1'b0;
            // A failure report outranks a clear in the same cycle
            if (state == ST_BUSY && i_op_error) err <= 1'b1;
            else if (next_state == ST_READ) err <= 1'b0;
        end
    end

    // Operation requests to the embedded algorithm
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prog_start       <= 1'b0;
            o_program_location <= '0;
            o_program_word     <= '0;
            o_erase_start      <= 1'b0;
            o_erase_bulk       <= 1'b0;
            o_erase_sectors    <= '0;
            o_target_secondary <= 1'b0;
            poll               <= 1'b0;
        end else begin
            o_prog_start  <= start_prog;
            o_erase_start <= start_bulk || start_sec;
            if (start_prog) begin
                o_program_location <= addr_l;
                o_program_word     <= i_data;
                poll               <= i_data[POLL_BIT];
            end
            if (start_bulk) o_erase_bulk <= 1'b1;
            else if (start_prog || add_sec) o_erase_bulk <= 1'b0;
            if (add_sec) o_erase_sectors <= o_erase_sectors | sel_l;
            else if (state == ST_READ) o_erase_sectors <= '0;
            // Secondary only when none of the primary selects is high
            if (wr_ok) o_target_secondary <= ~(|sel_l[7:0]);
        end
    end

    // Status word returned while an operation is under way
    wire        erasing = o_erase_bulk || er_sec;
    wire [15:0] status  = (16'h0001 << ERASE_TO_BIT) * erasing
                        | (16'h0001 << ERROR_BIT) * err
                        | (16'h0001 << TOGGLE_BIT) * tog
                        | (16'h0001 << POLL_BIT) * (~erasing & ~poll);
    wire        id_view = (state == ST_ID);
    wire [15:0] rd_mux  =
        (state == ST_BUSY) ? status :
        (id_view && i_addr[11:0] == ID_ADDR && sel_p && !sel_s) ? {8'h00, FLASH_ID} :
        (id_view && i_addr[11:0] == PROT_ADDR) ? {15'h0000, i_sector_protected} :
        i_array_rdata;

    // Read data, toggle bit and pin outputs
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata              <= RDATA_RST;
            tog                  <= 1'b0;
            o_suspend            <= 1'b0;
            o_busy_indicator_pin <= 1'b1;
            o_read_mode          <= 1'b1;
        end else begin
            if (rd_fall && (sel_p || sel_s)) begin
                o_rdata <= rd_mux;
                if (state == ST_BUSY && !err) tog <= ~tog;
            end
            o_suspend            <= (next_state == ST_SUSP);
            o_busy_indicator_pin <= !(next_state == ST_BUSY && !err);
            o_read_mode          <= (next_state == ST_READ);
        end
    end

    // Checks on the sequences above
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_unlocked;
        state == ST_UNL2 && wr_ok;
    endsequence
    sequence s_win_close;
        state == ST_WIN && tmo && !wr_ok;
    endsequence

    property p_unlock_gate;
        state == ST_READ && wr_ok && !c_aa |=> state == ST_READ;
    endproperty
    a_unlock_gate: assert property (p_unlock_gate)
        else $error("read mode left without first unlock byte");

    property p_busy_pin;
        state == ST_BUSY && !err |-> !o_busy_indicator_pin;
    endproperty
    a_busy_pin: assert property (p_busy_pin)
        else $error("busy pin high during operation");

    property p_id_read;
        state == ST_ID && rd_fall && sel_p && !sel_s && i_addr[11:0] == ID_ADDR
            |=> o_rdata == {8'h00, FLASH_ID};
    endproperty
    a_id_read: assert property (p_id_read)
        else $error("identifier read wrong");

    property p_prot_read;
        state == ST_ID && rd_fall && (sel_p || sel_s) && i_addr[11:0] == PROT_ADDR
            |=> o_rdata == {15'h0000, $past(i_sector_protected)};
    endproperty
    a_prot_read: assert property (p_prot_read)
        else $error("protection read wrong");

    property p_prog_data;
        state == ST_PROG && wr_ok
            |=> o_prog_start && o_program_word == $past(i_data) ##1 !o_prog_start;
    endproperty
    a_prog_data: assert property (p_prog_data)
        else $error("program request or word wrong");

    property p_erase_win;
        s_win_close |=> o_erase_start && state == ST_BUSY && !o_busy_indicator_pin;
    endproperty
    a_erase_win: assert property (p_erase_win)
        else $error("sector erase not started at window end");

    property p_bulk;
        state == ST_ERA5 && wr_ok && c_10a |=> o_erase_start && o_erase_bulk;
    endproperty
    a_bulk: assert property (p_bulk)
        else $error("bulk erase not started");

    property p_suspend_gate;
        state != ST_SUSP && wr_ok && c_b0e && !(state == ST_BUSY && er_sec && !err)
            |=> state != ST_SUSP;
    endproperty
    a_suspend_gate: assert property (p_suspend_gate)
        else $error("suspend taken outside sector erase");

    property p_resume;
        state == ST_SUSP && wr_ok && c_30e |=> state == ST_BUSY;
    endproperty
    a_resume: assert property (p_resume)
        else $error("resume not taken");

    property p_bypass;
        s_unlocked ##0 c_20a |=> state == ST_BYP;
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypass not entered");

    property p_timeout;
        in_seq && tmo && !wr_ok |=> state == ST_READ && o_read_mode;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("time-out did not return to read");
endmodule : flash_instruction_decoder
`default_nettype wire

// ### verification/flash_array_model.sv
// Array-side model: address-scrambled read data, protection and embedded algorithm timing
`timescale 1ns/1ps
`default_nettype none
module flash_array_model #(
    parameter int DLY = 30  // Algorithm length in cycles
) (
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    // From the decoder and the bus
    input  wire logic [15:0] i_addr,
    input  wire logic [7:0]  i_primary_sector_selects,
    input  wire logic        i_start,
    input  wire logic        i_suspend,
    input  wire logic        i_fail,
    // To the decoder
    output logic      [15:0] o_array_rdata,
    output logic             o_sector_protected,
    output logic             o_op_done,
    output logic             o_op_error
);
    logic [7:0] cnt;  // Cycles left, zero when idle
    // A scramble of the address, so that no two locations read alike
    assign o_array_rdata      = i_addr ^ 16'hc3c3;
    // Only primary sector 3 is protected
    assign o_sector_protected = i_primary_sector_selects[3];
    // A suspended erase keeps its count, so resume really continues it
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt        <= 8'h00;
            o_op_done  <= 1'b0;
            o_op_error <= 1'b0;
        end else begin
            o_op_done  <= (cnt == 8'h01) && !i_suspend && !i_fail;
            o_op_error <= (cnt == 8'h01) && !i_suspend && i_fail;
            if (i_start) begin
                cnt <= 8'(DLY);
            end else if (cnt != 8'h00 && !i_suspend) begin
                cnt <= cnt - 8'h01;
            end
        end
    end
endmodule : flash_array_model
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the flash instruction decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import flash_dec_pkg::*;
    localparam int          TO   = 20;        // Shortened byte time-out
    localparam int          WIN  = 10;        // Shortened append window
    localparam logic [7:0]  ID_V = 8'h5a;     // Arbitrary value
    localparam logic [15:0] M    = 16'hc3c3;  // Array model scramble
    typedef struct packed {
        logic w; logic [15:0] a; logic [15:0] d; logic [7:0] p; logic [3:0] s;
    } row_s;
    logic        clk, rst_n, wr_n, rd_n, prot, done, err, ps, es, eb, susp, tsec, busy, rmode;
    logic        fail;
    logic [15:0] addr, data, rdata, arr, pl, pw;
    logic [7:0]  psel;
    logic [3:0]  ssel;
    logic [11:0] esec;
    int          failures, tests_run, n_prog, n_erase;
    // Reads carry the expected word in d
    row_s rows [23] = '{
        '{1'b0, 16'h0100, 16'h0100 ^ M, 8'h01, 4'h0},
        '{1'b1, 16'h0aaa, 16'h00aa, 8'h01, 4'h0},
        '{1'b1, 16'h0554, 16'h0055, 8'h01, 4'h0},
        '{1'b1, 16'h0aaa, 16'h0090, 8'h01, 4'h0},
        '{1'b0, 16'h0002, {8'h00, ID_V}, 8'h01, 4'h0},
        '{1'b0, 16'h0004, 16'h0001, 8'h08, 4'h0},
        '{1'b0, 16'h0004, 16'h0000, 8'h01, 4'h0},
        '{1'b1, 16'h0000, 16'h00f0, 8'h01, 4'h0},
        '{1'b0, 16'h0002, 16'h0002 ^ M, 8'h01, 4'h0},
        '{1'b1, 16'h7aaa, 16'h00aa, 8'h02, 4'h0},
        '{1'b1, 16'h3554, 16'h0055, 8'h02, 4'h0},
        '{1'b1, 16'h1aaa, 16'h0090, 8'h02, 4'h0},
        '{1'b0, 16'hf002, {8'h00, ID_V}, 8'h02, 4'h0},
        '{1'b1, 16'h0000, 16'h00f0, 8'h02, 4'h0},
        '{1'b1, 16'h0aaa, 16'h00aa, 8'h00, 4'h2},
        '{1'b1, 16'h0554, 16'h0055, 8'h00, 4'h2},
        '{1'b1, 16'h0aaa, 16'h0090, 8'h00, 4'h2},
        '{1'b0, 16'h0002, 16'h0002 ^ M, 8'h00, 4'h2},
        '{1'b1, 16'h0000, 16'h00f0, 8'h00, 4'h2},
        '{1'b1, 16'h0aaa, 16'h00aa, 8'h01, 4'h0},
        '{1'b1, 16'h0554, 16'h0055, 8'h01, 4'h0},
        '{1'b1, 16'h0aaa, 16'h0077, 8'h01, 4'h0},
        '{1'b0, 16'h0002, 16'h0002 ^ M, 8'h01, 4'h0}
    };
    flash_instruction_decoder #(.TO_CYC(TO), .WIN_CYC(WIN), .FLASH_ID(ID_V)) u_dut (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_data(data),
        .i_low_byte_write_strobe_n(wr_n), .i_rd_n(rd_n), .i_primary_sector_selects(psel),
        .i_secondary_sector_selects(ssel), .o_rdata(rdata), .i_array_rdata(arr),
        .i_sector_protected(prot), .i_op_done(done), .i_op_error(err), .o_prog_start(ps),
        .o_program_location(pl), .o_program_word(pw), .o_erase_start(es), .o_erase_bulk(eb),
        .o_erase_sectors(esec), .o_suspend(susp), .o_target_secondary(tsec),
        .o_busy_indicator_pin(busy), .o_read_mode(rmode));
    flash_array_model u_array (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_primary_sector_selects(psel),
        .i_start(ps | es), .i_suspend(susp), .i_fail(fail), .o_array_rdata(arr),
        .o_sector_protected(prot), .o_op_done(done), .o_op_error(err));
    // Clock at 40 MHz
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Count start pulses so that a missing or doubled one shows
    always @(posedge clk) begin
        if (ps === 1'b1) n_prog++;
        if (es === 1'b1) n_erase++;
    end
    // Verdict and end of run
    task automatic close_out;
        if (failures == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out
    // Compare one value
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Write cycle; address and data are wrong outside their latch phase to prove it
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [7:0] p,
                      input logic [3:0] s);
        @(posedge clk) #1;
        addr = a; data = ~d; psel = p; ssel = s; wr_n = 1'b0;
        @(posedge clk) #1;
        addr = ~a; data = d; wr_n = 1'b1;
        repeat (2) @(posedge clk) #1;
        psel = 8'h00; ssel = 4'h0;
    endtask : wr
    // Read cycle; data sampled once the register has settled
    task automatic rd(input logic [15:0] a, input logic [7:0] p, output logic [15:0] q,
                      input logic [3:0] s = 4'h0);
        @(posedge clk) #1;
        addr = a; psel = p; ssel = s; rd_n = 1'b0;
        @(posedge clk) #1;
        rd_n = 1'b1;
        @(posedge clk) #1;
        q = rdata; psel = 8'h00; ssel = 4'h0;
    endtask : rd
    // Both unlock writes
    task automatic unl(input logic [7:0] p, input logic [3:0] s);
        wr(16'h0aaa, 16'h00aa, p, s);
        wr(16'h0554, 16'h0055, p, s);
    endtask : unl
    // Bounded wait for the busy pin
    task automatic wait_busy(input logic lvl);
        int k;
        for (k = 0; k < 200 && busy !== lvl; k++) @(posedge clk) #1;
        if (busy !== lvl) begin
            failures++;
            close_out();
        end
    endtask : wait_busy
    // Hang guard
    initial begin
        #500000;
        failures++;
        close_out();
    end
    // Main sequence
    initial begin
        logic [15:0] q, q2;
        addr = 16'h0000; data = 16'h0000; wr_n = 1'b1; rd_n = 1'b1;
        psel = 8'h00; ssel = 4'h0; fail = 1'b0; rst_n = 1'b0;
        failures = 0; tests_run = 0; n_prog = 0; n_erase = 0;
        repeat (3) @(posedge clk);
        #1 rst_n = 1'b1;
        chk(busy, 1'b1);
        chk(rmode, 1'b1);
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d, rows[i].p, rows[i].s);
            else begin
                rd(rows[i].a, rows[i].p, q, rows[i].s);
                chk(q, rows[i].d);
            end
        end
        // Word program: nothing starts before the data write
        unl(8'h01, 4'h0);
        wr(16'h0aaa, 16'h00a0, 8'h01, 4'h0);
        chk(16'(n_prog), 16'h0000);
        wr(16'h1234, 16'h007f, 8'h01, 4'h0);
        chk(16'(n_prog), 16'h0001);
        chk(pl, 16'h1234);
        chk(pw, 16'h007f);
        chk(busy, 1'b0);
        rd(16'h1234, 8'h01, q);
        rd(16'h1234, 8'h01, q2);
        chk(q[7], 1'b1);
        chk(q[6] ^ q2[6], 1'b1);
        wait_busy(1'b1);
        rd(16'h1234, 8'h01, q);
        chk(q, 16'h1234 ^ M);
        // Two-sector erase, suspend and resume
        unl(8'h01, 4'h0);
        wr(16'h0aaa, 16'h0080, 8'h01, 4'h0);
        unl(8'h01, 4'h0);
        wr(16'h4000, 16'h0030, 8'h04, 4'h0);
        wr(16'h5000, 16'h0030, 8'h10, 4'h0);
        chk(16'(n_erase), 16'h0000);
        wait_busy(1'b0);
        chk(es, 1'b1);
        @(posedge clk) #1;
        chk(16'(n_erase), 16'h0001);
        chk(esec, 12'h014);
        chk(eb, 1'b0);
        rd(16'h4000, 8'h04, q);
        chk(q & 16'h0088, 16'h0008);
        wr(16'h0000, 16'h00b0, 8'h01, 4'h0);
        chk(susp, 1'b1);
        wr(16'h0000, 16'h0030, 8'h01, 4'h0);
        chk(susp, 1'b0);
        wait_busy(1'b1);
        wr(16'h0000, 16'h00b0, 8'h01, 4'h0);
        chk(susp, 1'b0);
        wr(16'h0000, 16'h0030, 8'h01, 4'h0);
        chk(rmode, 1'b1);
        // Bulk erase of the secondary array
        unl(8'h00, 4'h1);
        wr(16'h0aaa, 16'h0080, 8'h00, 4'h1);
        unl(8'h00, 4'h1);
        wr(16'h0aaa, 16'h0010, 8'h00, 4'h1);
        chk(16'(n_erase), 16'h0002);
        chk(eb, 1'b1);
        chk(tsec, 1'b1);
        wait_busy(1'b1);
        // Bypass: two-write program, then exit
        unl(8'h01, 4'h0);
        wr(16'h0aaa, 16'h0020, 8'h01, 4'h0);
        chk(rmode, 1'b0);
        wr(16'h0010, 16'h00a0, 8'h01, 4'h0);
        wr(16'h0246, 16'hbeef, 8'h01, 4'h0);
        chk(16'(n_prog), 16'h0002);
        chk(pw, 16'hbeef);
        wait_busy(1'b1);
        wr(16'h0000, 16'h0090, 8'h01, 4'h0);
        wr(16'h0000, 16'h0000, 8'h01, 4'h0);
        chk(rmode, 1'b1);
        // Gap longer than the time-out drops the sequence
        wr(16'h0aaa, 16'h00aa, 8'h01, 4'h0);
        repeat (TO + 5) @(posedge clk);
        wr(16'h0554, 16'h0055, 8'h01, 4'h0);
        wr(16'h0aaa, 16'h00a0, 8'h01, 4'h0);
        wr(16'h0300, 16'h1111, 8'h01, 4'h0);
        chk(16'(n_prog), 16'h0002);
        // Failed program: error bit until the reset instruction
        fail = 1'b1;
        unl(8'h01, 4'h0);
        wr(16'h0aaa, 16'h00a0, 8'h01, 4'h0);
        wr(16'h0400, 16'h0001, 8'h01, 4'h0);
        wait_busy(1'b1);
        fail = 1'b0;
        rd(16'h0400, 8'h01, q);
        chk(q[5], 1'b1);
        wr(16'h0000, 16'h00f0, 8'h01, 4'h0);
        rd(16'h0400, 8'h01, q);
        chk(q, 16'h0400 ^ M);
        // Reset in mid-sequence
        unl(8'h01, 4'h0);
        rst_n = 1'b0;
        #1 chk(rmode, 1'b1);
        @(posedge clk) #1 rst_n = 1'b1;
        rd(16'h0002, 8'h01, q);
        chk(q, 16'h0002 ^ M);
        close_out();
    end
endmodule : testbench
`default_nettype wire
